// ---- interrupt_enable_bank.v ----
// Interrupt-enable register bank with the pending flags it gates and the interrupt request.
// Assumes the serial-interface decoder drives reg_* on clk_sys, and event detectors give
// one-cycle pulses on clk_sys; nothing here needs synchronising.
//
// Summary of operation
// - Transceiver enable bit 4 lets a bus-silence event raise the interrupt.
// - Transceiver bit 3 gates second LIN wake-up; reserved on single-LIN builds.
// - Transceiver bit 2 gates first LIN wake-up; one permits.
// - Transceiver bit 1 gates CAN failure; one permits.
// - Transceiver bit 0 gates CAN wake-up; one permits.
// - Bank-0 edge enables: pin n fall on odd bit, rise on even bit.
// - Bank-0 fault enables: short-circuit enable on odd bits, one enables.
// - Bank-0 open-load enables on even bits: zero enables, one disables.
// - Bank-1 edge enables: same layout for pins 5 to 8.
// - Bank-1 fault enables: short-circuit on bits 7,5,3,1, one enables.
// - Bank-1 open-load enables on bits 6,4,2,0 are active low.
// - Bank-0 enable registers absent when the build has no high-voltage pins.
// - Bank-1 enable registers absent on partial-networking builds or without pins 5-8.
// - Short and open-load events set pending flags matching enable positions.
// - Bank-1 edges set pending flags matching bank-1 edge enable layout.
`timescale 1ns/100ps
`include "irq_enable_bank_consts.vh"

module interrupt_enable_bank
#(
   parameter HAS_LIN_SECOND = 1,
   parameter HAS_BANK0      = 1,
   parameter HAS_BANK1      = 1
)
(
   input  wire       clk_sys,
   input  wire       reset_n,
   input  wire [6:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [4:0] trx_evt,
   input  wire [7:0] bank0_edge_evt,
   input  wire [7:0] bank0_fault_evt,
   input  wire [7:0] bank1_edge_evt,
   input  wire [7:0] bank1_fault_evt,
   output reg  [7:0] reg_rdata_r,
   output reg        reg_hit_r,
   output reg        irq_req_r
);

   ////////////////////////////////////////////////////////////////////////////////
   // Variant masks: absent registers and reserved bits read zero and take no writes
   // Masking at write time keeps reserved flops at zero, so the read path needs no mask
   wire [7:0] trx_mask = (HAS_LIN_SECOND != 0) ? `TRX_MASK_DUAL_LIN
                                               : `TRX_MASK_SINGLE_LIN;
   wire       b0_on    = (HAS_BANK0 != 0);
   wire       b1_on    = (HAS_BANK1 != 0);
   wire [7:0] b0_mask  = b0_on ? 8'hff : 8'h00;
   wire [7:0] b1_mask  = b1_on ? 8'hff : 8'h00;

   reg  [7:0] trx_en_r;
   reg  [7:0] b0_edge_en_r;
   reg  [7:0] b0_fault_en_r;
   reg  [7:0] b1_edge_en_r;
   reg  [7:0] b1_fault_en_r;
   reg  [7:0] trx_pend_r;
   reg  [7:0] b0_edge_pend_r;
   reg  [7:0] b0_fault_pend_r;
   reg  [7:0] b1_edge_pend_r;
   reg  [7:0] b1_fault_pend_r;

   wire wr_trx_en   = reg_wr && (reg_addr == `OFS_TRX_IRQ_EN);
   wire wr_b0e_en   = reg_wr && (reg_addr == `OFS_B0_EDGE_IRQ_EN);
   wire wr_b0f_en   = reg_wr && (reg_addr == `OFS_B0_FAULT_IRQ_EN);
   wire wr_b1e_en   = reg_wr && (reg_addr == `OFS_B1_EDGE_IRQ_EN);
   wire wr_b1f_en   = reg_wr && (reg_addr == `OFS_B1_FAULT_IRQ_EN);
   wire wr_trx_pend = reg_wr && (reg_addr == `OFS_TRX_PEND);
   wire wr_b0e_pend = reg_wr && (reg_addr == `OFS_B0_EDGE_PEND);
   wire wr_b0f_pend = reg_wr && (reg_addr == `OFS_B0_FAULT_PEND);
   wire wr_b1e_pend = reg_wr && (reg_addr == `OFS_B1_EDGE_PEND);
   wire wr_b1f_pend = reg_wr && (reg_addr == `OFS_B1_FAULT_PEND);

   ////////////////////////////////////////////////////////////////////////////////
   // Enable registers; the bit meanings are applied where the request is formed
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         trx_en_r      <= `RST_ENABLE;
         b0_edge_en_r  <= `RST_ENABLE;
         b0_fault_en_r <= `RST_ENABLE;
         b1_edge_en_r  <= `RST_ENABLE;
         b1_fault_en_r <= `RST_ENABLE;
      end
      else
      begin
         if (wr_trx_en)
            trx_en_r <= reg_wdata & trx_mask;
         if (wr_b0e_en)
            b0_edge_en_r <= reg_wdata & b0_mask;
         if (wr_b0f_en)
            b0_fault_en_r <= reg_wdata & b0_mask;
         if (wr_b1e_en)
            b1_edge_en_r <= reg_wdata & b1_mask;
         if (wr_b1f_en)
            b1_fault_en_r <= reg_wdata & b1_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pending flags: write one to clear; an event in the clearing cycle wins so none is lost
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         trx_pend_r      <= `RST_PEND;
         b0_edge_pend_r  <= `RST_PEND;
         b0_fault_pend_r <= `RST_PEND;
         b1_edge_pend_r  <= `RST_PEND;
         b1_fault_pend_r <= `RST_PEND;
      end
      else
      begin
         trx_pend_r      <= ((trx_pend_r & ~({8{wr_trx_pend}} & reg_wdata))
                            | {3'h0, trx_evt}) & trx_mask;
         b0_edge_pend_r  <= ((b0_edge_pend_r & ~({8{wr_b0e_pend}} & reg_wdata))
                            | bank0_edge_evt) & b0_mask;
         b0_fault_pend_r <= ((b0_fault_pend_r & ~({8{wr_b0f_pend}} & reg_wdata))
                            | bank0_fault_evt) & b0_mask;
         b1_edge_pend_r  <= ((b1_edge_pend_r & ~({8{wr_b1e_pend}} & reg_wdata))
                            | bank1_edge_evt) & b1_mask;
         b1_fault_pend_r <= ((b1_fault_pend_r & ~({8{wr_b1f_pend}} & reg_wdata))
                            | bank1_fault_evt) & b1_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Effective enables: open-load bits are active low, so flip them before gating
   wire [7:0] b0_fault_gate = (b0_fault_en_r ^ `OPENLOAD_BITS) & b0_mask;
   wire [7:0] b1_fault_gate = (b1_fault_en_r ^ `OPENLOAD_BITS) & b1_mask;

   wire irq_nxt = |(trx_pend_r      & trx_en_r)
                | |(b0_edge_pend_r  & b0_edge_en_r)
                | |(b0_fault_pend_r & b0_fault_gate)
                | |(b1_edge_pend_r  & b1_edge_en_r)
                | |(b1_fault_pend_r & b1_fault_gate);

   ////////////////////////////////////////////////////////////////////////////////
   // Read port and registered interrupt request; reads have no side effect
   reg [7:0] rdata_nxt;
   reg       hit_nxt;

   always @*
   begin
      rdata_nxt = `RD_ZERO;
      hit_nxt   = 1'b1;
      case (reg_addr)
         `OFS_TRX_IRQ_EN      : rdata_nxt = trx_en_r;
         `OFS_TRX_PEND        : rdata_nxt = trx_pend_r;
         // An absent bank answers with data 00 and no hit, so the shifter never sees a stale byte
         `OFS_B0_EDGE_IRQ_EN  :
         begin
            rdata_nxt = b0_edge_en_r;
            hit_nxt   = b0_on;
         end
         `OFS_B0_FAULT_IRQ_EN :
         begin
            rdata_nxt = b0_fault_en_r;
            hit_nxt   = b0_on;
         end
         `OFS_B0_EDGE_PEND    :
         begin
            rdata_nxt = b0_edge_pend_r;
            hit_nxt   = b0_on;
         end
         `OFS_B0_FAULT_PEND   :
         begin
            rdata_nxt = b0_fault_pend_r;
            hit_nxt   = b0_on;
         end
         `OFS_B1_EDGE_IRQ_EN  :
         begin
            rdata_nxt = b1_edge_en_r;
            hit_nxt   = b1_on;
         end
         `OFS_B1_FAULT_IRQ_EN :
         begin
            rdata_nxt = b1_fault_en_r;
            hit_nxt   = b1_on;
         end
         `OFS_B1_EDGE_PEND    :
         begin
            rdata_nxt = b1_edge_pend_r;
            hit_nxt   = b1_on;
         end
         `OFS_B1_FAULT_PEND   :
         begin
            rdata_nxt = b1_fault_pend_r;
            hit_nxt   = b1_on;
         end
         default              : hit_nxt = 1'b0;
      endcase
   end

   // Read data holds until the next read so the serial shifter can take it late
   always @(posedge clk_sys)
   begin
      if (!reset_n)
      begin
         reg_rdata_r <= `RD_ZERO;
         reg_hit_r   <= 1'b0;
         irq_req_r   <= 1'b0;
      end
      else
      begin
         if (reg_rd)
         begin
            reg_rdata_r <= rdata_nxt;
            reg_hit_r   <= hit_nxt;
         end
         irq_req_r <= irq_nxt;
      end
   end

endmodule // interrupt_enable_bank

// ---- irq_enable_bank_consts.vh ----
// Constants for the interrupt-enable bank: register offsets, masks and reset values.
// Assumes the serial-interface frame decoder presents 7-bit register addresses.
`ifndef IRQ_ENABLE_BANK_CONSTS_VH
`define IRQ_ENABLE_BANK_CONSTS_VH

// Enable register offsets
`define OFS_TRX_IRQ_EN      7'h23
`define OFS_B0_EDGE_IRQ_EN  7'h37
`define OFS_B0_FAULT_IRQ_EN 7'h38
`define OFS_B1_EDGE_IRQ_EN  7'h47
`define OFS_B1_FAULT_IRQ_EN 7'h48

// Pending status register offsets
`define OFS_TRX_PEND        7'h63
`define OFS_B0_EDGE_PEND    7'h64
`define OFS_B0_FAULT_PEND   7'h65
`define OFS_B1_EDGE_PEND    7'h66
`define OFS_B1_FAULT_PEND   7'h67

// Transceiver enable field positions
`define BIT_BUS_SILENCE     4
`define BIT_LIN_SECOND_WAKE 3
`define BIT_LIN_FIRST_WAKE  2
`define BIT_CAN_FAILURE     1
`define BIT_CAN_WAKE        0

// Writable bits of the transceiver enable register, with and without a second LIN
`define TRX_MASK_DUAL_LIN   8'h1f
`define TRX_MASK_SINGLE_LIN 8'h17

// Open-load enables sit on even bits and use inverted polarity
`define OPENLOAD_BITS       8'h55

// Reset values
`define RST_ENABLE          8'h00
`define RST_PEND            8'h00
`define RD_ZERO             8'h00

`endif

// ---- interrupt_enable_bank_sva.sv ----
// Checker for the interrupt-enable bank, watching only its top-level ports.
// Assumes one clock domain and the synchronous active-low reset of the bank.
`timescale 1ns/100ps
module interrupt_enable_bank_sva
#(
   parameter HAS_LIN_SECOND = 1,
   parameter HAS_BANK0      = 1,
   parameter HAS_BANK1      = 1
)
(
   input wire       clk_sys,
   input wire       reset_n,
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [4:0] trx_evt,
   input wire [7:0] bank0_edge_evt,
   input wire [7:0] bank0_fault_evt,
   input wire [7:0] bank1_edge_evt,
   input wire [7:0] bank1_fault_evt,
   input wire [7:0] reg_rdata_r,
   input wire       reg_hit_r,
   input wire       irq_req_r
);
   // Any event pulse at all; the request may only rise after one or after a write
   wire ev = |{trx_evt, bank0_edge_evt, bank0_fault_evt, bank1_edge_evt, bank1_fault_evt};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   property p_rsv; reg_rd && reg_addr == 7'h23 |=> reg_rdata_r[7:5] == 3'b000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved enable bits read nonzero");
   property p_trx_wr; reg_wr && reg_addr == 7'h23 ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 7'h23
      |=> reg_rdata_r == ($past(reg_wdata, 3) & (HAS_LIN_SECOND ? 8'h1f : 8'h17)); endproperty
   a_trx_wr: assert property (p_trx_wr) else $error("transceiver enable readback wrong");
   property p_bank_wr; HAS_BANK0 && HAS_BANK1 && reg_wr && reg_addr inside {7'h37, 7'h38, 7'h47, 7'h48} ##1 !reg_wr
      ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2) |=> reg_rdata_r == $past(reg_wdata, 3); endproperty
   a_bank_wr: assert property (p_bank_wr) else $error("bank enable readback wrong");
   property p_unmap; reg_rd && reg_addr == 7'h30 |=> !reg_hit_r && reg_rdata_r == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not empty");
   property p_b0_hit; reg_rd && reg_addr == 7'h38 |=> reg_hit_r == (HAS_BANK0 != 0); endproperty
   a_b0_hit: assert property (p_b0_hit) else $error("bank0 presence wrong");
   property p_b1_hit; reg_rd && reg_addr == 7'h48 |=> reg_hit_r == (HAS_BANK1 != 0); endproperty
   a_b1_hit: assert property (p_b1_hit) else $error("bank1 presence wrong");
   property p_irq_rise; $rose(irq_req_r) |-> $past(ev, 2) || $past(ev, 3) || $past(reg_wr) || $past(reg_wr, 2);
   endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("request rose without cause");
   property p_irq_fall; $fell(irq_req_r) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("request fell without a write");
endmodule // interrupt_enable_bank_sva

bind interrupt_enable_bank interrupt_enable_bank_sva #(.HAS_LIN_SECOND(HAS_LIN_SECOND), .HAS_BANK0(HAS_BANK0),
   .HAS_BANK1(HAS_BANK1)) u_sva (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .trx_evt,
   .bank0_edge_evt, .bank0_fault_evt, .bank1_edge_evt, .bank1_fault_evt, .reg_rdata_r, .reg_hit_r, .irq_req_r);

// ---- host_model.sv ----
// Host model driving the decoded register port of the bank.
// Assumes read data settles on the edge that takes the read strobe.
`timescale 1ns/100ps
module host_model
(
   input  wire       clk_sys,
   input  wire [7:0] reg_rdata_r,
   input  wire       reg_hit_r,
   output reg  [6:0] reg_addr,
   output reg  [7:0] reg_wdata,
   output reg        reg_wr,
   output reg        reg_rd
);
   initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
   // Released lines carry inverted values; inverted 7'h37, 7'h38, 7'h47 and 7'h48 land on one another
   task wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {~a, ~v, 1'b0};
   endtask
   task rd(input logic [6:0] a, output logic [7:0] v, output logic h);
      @(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk_sys) {reg_addr, reg_rd} <= {~a, 1'b0};
      #1 v = reg_rdata_r;
      h = reg_hit_r;
   endtask
endmodule // host_model

// ---- tb.sv ----
// Bench for the interrupt-enable bank: register access, gating and pending flags.
// Assumes host_model on the register port and the checker bound into the bank.
`timescale 1ns/100ps
module tb;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic [39:0] evt = '0;
   wire  [6:0]  reg_addr;
   wire  [7:0]  reg_wdata, reg_rdata_r;
   wire         reg_wr, reg_rd, reg_hit_r, irq_req_r;
   wire  [7:0]  rdata_lite;
   wire         hit_lite, irq_lite;
   logic [7:0]  d;
   logic        h;
   logic [6:0]  regs [5] = '{7'h23, 7'h37, 7'h38, 7'h47, 7'h48};
   int          n_errors = 0;
   int          checked = 0;
   initial forever #2.5 clk_sys = ~clk_sys;
   host_model host (.clk_sys, .reg_rdata_r, .reg_hit_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
   interrupt_enable_bank DUT (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .trx_evt(evt[4:0]),
      .bank0_edge_evt(evt[15:8]), .bank0_fault_evt(evt[23:16]), .bank1_edge_evt(evt[31:24]),
      .bank1_fault_evt(evt[39:32]), .reg_rdata_r, .reg_hit_r, .irq_req_r);
   // Minimal build: one LIN channel and no pin banks, on the same host bus and events
   interrupt_enable_bank #(.HAS_LIN_SECOND(0), .HAS_BANK0(0), .HAS_BANK1(0)) dut_lite (.clk_sys, .reset_n,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .trx_evt(evt[4:0]), .bank0_edge_evt(evt[15:8]),
      .bank0_fault_evt(evt[23:16]), .bank1_edge_evt(evt[31:24]), .bank1_fault_evt(evt[39:32]),
      .reg_rdata_r(rdata_lite), .reg_hit_r(hit_lite), .irq_req_r(irq_lite));
   ////////////////////////////////////////
   task chk_byte(input logic [7:0] g, e);
      checked++;
      if (g !== e) begin n_errors++; $display("[FAIL] %0t data %h expected %h", $time, g, e); end
   endtask
   task chk_bit(input logic g, e);
      checked++;
      if (g !== e) begin n_errors++; $display("[FAIL] %0t flag %b expected %b", $time, g, e); end
   endtask
   // Request is a level, so it is looked at once it has had time to settle
   task irq_is(input logic e, e2);
      repeat (3) @(posedge clk_sys);
      #1 chk_bit(irq_req_r, e);
      chk_bit(irq_lite, e2);
   endtask
   // Event while disabled stays silent, enabling raises the request, clearing drops it
   // The minimal build takes part only where lt says its flag exists
   task gate(input logic [6:0] ea, pa, input logic [39:0] ev, input logic [7:0] off, on, input logic lt);
      logic [7:0] pb;
      pb = ev[7:0] | ev[15:8] | ev[23:16] | ev[31:24] | ev[39:32];
      host.wr(ea, off);
      @(posedge clk_sys) evt <= ev;
      @(posedge clk_sys) evt <= '0;
      irq_is(1'b0, 1'b0);
      host.rd(pa, d, h);
      chk_byte(d, pb);
      chk_byte(rdata_lite, lt ? pb : 8'h00);
      host.wr(ea, on);
      irq_is(1'b1, lt);
      host.wr(pa, pb);
      irq_is(1'b0, 1'b0);
   endtask
   task close_out;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   ////////////////////////////////////////
   // Reset, reset values and readback, then each transceiver enable and, per bank, edge bit 7 and fault bits 6 and 1 gated one at a time
   initial
   begin
      repeat (3) @(posedge clk_sys);
      reset_n <= 1'b1;
      foreach (regs[i])
      begin
         host.rd(regs[i], d, h);
         chk_byte(d, 8'h00);
         chk_bit(h, 1'b1);
         chk_bit(hit_lite, i == 0);
         host.wr(regs[i], 8'ha5);
         host.rd(regs[i], d, h);
         chk_byte(d, (i == 0) ? 8'h05 : 8'ha5);
         chk_byte(rdata_lite, (i == 0) ? 8'h05 : 8'h00);
         host.wr(regs[i], 8'h00);
      end
      host.wr(7'h23, 8'hff);
      host.rd(7'h23, d, h);
      chk_byte(d, 8'h1f);
      chk_byte(rdata_lite, 8'h17);
      host.wr(7'h30, 8'hff);
      host.rd(7'h30, d, h);
      chk_byte(d, 8'h00);
      chk_bit(h, 1'b0);
      chk_bit(hit_lite, 1'b0);
      for (int k = 0; k < 5; k++)
         gate(7'h23, 7'h63, 40'h1 << k, 8'h1f ^ (8'h1 << k), 8'h1 << k, k != 3);
      // Event and clear of the same flag in one cycle: the event must survive
      fork
         host.wr(7'h63, 8'h10);
         begin
            @(posedge clk_sys) evt <= 40'h10;
            @(posedge clk_sys) evt <= '0;
         end
      join
      host.rd(7'h63, d, h);
      chk_byte(d, 8'h10);
      chk_byte(rdata_lite, 8'h10);
      irq_is(1'b1, 1'b1);
      host.wr(7'h63, 8'h10);
      irq_is(1'b0, 1'b0);
      for (int b = 0; b < 2; b++)
      begin
         gate(7'h37 + 7'(b * 16), 7'h64 + 7'(b * 2), 40'h80 << (b * 16 + 8), 8'h00, 8'h80, 1'b0);
         gate(7'h38 + 7'(b * 16), 7'h65 + 7'(b * 2), 40'h40 << (b * 16 + 16), 8'hff, 8'hbf, 1'b0);
         gate(7'h38 + 7'(b * 16), 7'h65 + 7'(b * 2), 40'h02 << (b * 16 + 16), 8'h55, 8'h57, 1'b0);
      end
      close_out;
   end
   // Watchdog in case the run hangs
   initial
   begin
      #100000;
      n_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      close_out;
   end
endmodule // tb
